// File: include/timed_pattern_output_defines.svh
`ifndef TIMED_PATTERN_OUTPUT_DEFINES_SVH
`define TIMED_PATTERN_OUTPUT_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define TPO_OFF_STAGED_A   8'h00
`define TPO_OFF_STAGED_B   8'h04
`define TPO_OFF_VALUE_A    8'h08
`define TPO_OFF_VALUE_B    8'h0C
`define TPO_OFF_DIR_A      8'h10
`define TPO_OFF_DIR_B      8'h14
`define TPO_OFF_ENABLE_A   8'h18
`define TPO_OFF_ENABLE_B   8'h1C
`define TPO_OFF_TRIG_SEL   8'h20
`define TPO_OFF_GROUP_MODE 8'h24
`define TPO_OFF_PIN_LEVEL  8'h28

// ************************************************************
// reset values and field layout
// ************************************************************
`define TPO_RST_ZERO       8'h00
`define TPO_RST_TRIG_SEL   8'hFF
`define TPO_RST_GROUP_MODE 8'hF0
`define TPO_MODE_RSVD_MASK 8'hF0
`define TPO_MODE_NOV_LSB   0
`define TPO_SEL_FIELD_W    2
`define TPO_GROUP_W        4

`endif

// File: include/timed_pattern_output_pkg.sv
package timed_pattern_output_pkg;

	// ************************************************************
	// types
	// ************************************************************
	// trigger channel picked by a group select field
	typedef enum logic [1:0] {
		CHAN_0 = 2'h0,
		CHAN_1 = 2'h1,
		CHAN_2 = 2'h2,
		CHAN_3 = 2'h3
	} chan_type;

	// output mode of one group
	typedef enum logic {
		MODE_NORMAL  = 1'h0,
		MODE_NONOVER = 1'h1
	} group_mode_type;

	// ************************************************************
	// functions
	// ************************************************************
	// register hit on the low address byte
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// event of the selected channel
	function automatic logic chan_pick(input logic [3:0] ev, input chan_type ch);
		chan_pick = ev[ch];
	endfunction : chan_pick

endpackage : timed_pattern_output_pkg

// File: include/group_update_if.sv
`timescale 1ns/10ps
interface group_update_if;
	logic [3:0]  cm_a;
	logic [3:0]  cm_b;
	logic [7:0]  chan_sel;
	logic [3:0]  nonoverlap;
	logic [15:0] staged;
	logic [15:0] enable;
	logic [15:0] load;

	modport ctrl (output cm_a, output cm_b, output chan_sel, output nonoverlap,
		output staged, output enable, input load);
	modport calc (input cm_a, input cm_b, input chan_sel, input nonoverlap,
		input staged, input enable, output load);
endinterface : group_update_if

// File: design/pattern_group_update.sv
`timescale 1ns/10ps
`include "timed_pattern_output_defines.svh"
module pattern_group_update
	import timed_pattern_output_pkg::*;
(
	group_update_if.calc upd
);

	// ************************************************************
	// per-group transfer mask
	// ************************************************************
	// a bit loads when enabled and its group trigger fires
	always_comb begin
		logic     ev_a;
		logic     ev_b;
		chan_type ch;
		ev_a = 1'b0;
		ev_b = 1'b0;
		ch = CHAN_3;
		upd.load = 16'h0000;
		for (int g = 0; g < 4; g++) begin
			ch = chan_type'(upd.chan_sel[g*`TPO_SEL_FIELD_W +: `TPO_SEL_FIELD_W]);
			ev_a = chan_pick(upd.cm_a, ch);
			ev_b = chan_pick(upd.cm_b, ch);
			for (int b = 0; b < `TPO_GROUP_W; b++) begin
				if (upd.nonoverlap[g] == MODE_NONOVER) begin
					// zeros go at match b, every bit at match a
					upd.load[g*4+b] = upd.enable[g*4+b] &
						(ev_a | (ev_b & ~upd.staged[g*4+b]));
				end else begin
					upd.load[g*4+b] = upd.enable[g*4+b] & ev_a;
				end
			end
		end
	end

endmodule : pattern_group_update

// File: design/timed_pattern_output.sv
`timescale 1ns/10ps
`include "timed_pattern_output_defines.svh"
// Operation
// - mode register resets to F0, also in standby
// - mode bits 7..4 read one, ignore writes
// - mode bit g picks normal or non-overlap group
// - normal group updates only on match A
// - non-overlap group uses match A and B
// - pattern pin needs direction and enable set
// - pin shows value, trigger loads staged bit
// - enabled input pin: value read-only, still loaded
// - falls at match B, rises at match A
// - two-bit field picks channel, resets to three
// - per-pin enable gates transfer, resets zero
// - match B transfers only staged zeros
module timed_pattern_output
	import timed_pattern_output_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic              hw_standby_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic [3:0]        cm_a_i,
	input  wire logic [3:0]        cm_b_i,
	input  wire logic [15:0]       pin_i,
	output logic      [15:0]       pin_o,
	output logic      [15:0]       pin_oe_o,
	output logic      [15:0]       pattern_active_o
);

	// ************************************************************
	// elaboration check
	// ************************************************************
	if (ADDR_W < 8) begin : g_addr_check
		$error("ADDR_W must be at least 8");
	end

	// ************************************************************
	// declarations
	// ************************************************************
	logic [15:0] staged_reg;
	logic [15:0] value_reg;
	logic [15:0] value_next;
	logic [15:0] dir_reg;
	logic [15:0] enable_reg;
	logic [7:0]  trig_sel_reg;
	logic [7:0]  group_mode_reg;
	logic [15:0] pin_meta_reg;
	logic [15:0] pin_sync_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        pslverr_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [15:0] pin_out_reg;
	logic [15:0] pin_oe_reg;
	logic [15:0] active_reg;
	logic [7:0]  addr_lo;
	logic        setup_phase;
	logic        wr_fire;
	logic [15:0] ro_mask;
	logic [15:0] sw_mask;

	group_update_if upd_if ();

	// ************************************************************
	// bus phase decode
	// ************************************************************
	// writes land on the access edge that sees pready high
	// an errored transfer (upper address bits set) leaves every register alone
	assign addr_lo     = paddr_i[7:0];
	assign setup_phase = psel_i & ~penable_i;
	assign wr_fire     = psel_i & penable_i & pwrite_i & pready_reg & pstrb_i[0] & ~pslverr_reg;

	// ************************************************************
	// pin input synchroniser
	// ************************************************************
	// two stages before any logic looks at the pins
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta_reg <= 16'h0000;
			pin_sync_reg <= 16'h0000;
		end else if (ce_i) begin
			pin_meta_reg <= pin_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ************************************************************
	// staged pattern registers
	// ************************************************************
	// software restages between matches
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			staged_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
		end else if (ce_i) begin
			if (hw_standby_i) begin
				staged_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_STAGED_A)) begin
				staged_reg[7:0] <= pwdata_i[7:0];
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_STAGED_B)) begin
				staged_reg[15:8] <= pwdata_i[7:0];
			end
		end
	end

	// ************************************************************
	// direction and enable registers
	// ************************************************************
	// direction drives the pin enable
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dir_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
		end else if (ce_i) begin
			if (hw_standby_i) begin
				dir_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_DIR_A)) begin
				dir_reg[7:0] <= pwdata_i[7:0];
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_DIR_B)) begin
				dir_reg[15:8] <= pwdata_i[7:0];
			end
		end
	end

	// per-pin transfer enable
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			enable_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
		end else if (ce_i) begin
			if (hw_standby_i) begin
				enable_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_ENABLE_A)) begin
				enable_reg[7:0] <= pwdata_i[7:0];
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_ENABLE_B)) begin
				enable_reg[15:8] <= pwdata_i[7:0];
			end
		end
	end

	// ************************************************************
	// trigger select and group mode
	// ************************************************************
	// channel select per group
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			trig_sel_reg <= `TPO_RST_TRIG_SEL;
		end else if (ce_i) begin
			if (hw_standby_i) begin
				trig_sel_reg <= `TPO_RST_TRIG_SEL;
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_TRIG_SEL)) begin
				trig_sel_reg <= pwdata_i[7:0];
			end
		end
	end

	// reserved upper bits stay one whatever is written
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			group_mode_reg <= `TPO_RST_GROUP_MODE;
		end else if (ce_i) begin
			if (hw_standby_i) begin
				group_mode_reg <= `TPO_RST_GROUP_MODE;
			end else if (wr_fire && reg_hit(addr_lo, `TPO_OFF_GROUP_MODE)) begin
				group_mode_reg <= (pwdata_i[7:0] & ~`TPO_MODE_RSVD_MASK) |
					`TPO_MODE_RSVD_MASK;
			end
		end
	end

	// ************************************************************
	// group transfer calculation
	// ************************************************************
	assign upd_if.cm_a       = cm_a_i;
	assign upd_if.cm_b       = cm_b_i;
	assign upd_if.chan_sel   = trig_sel_reg;
	assign upd_if.nonoverlap = group_mode_reg[`TPO_MODE_NOV_LSB +: 4];
	assign upd_if.staged     = staged_reg;
	assign upd_if.enable     = enable_reg;

	pattern_group_update u_update (
		.upd (upd_if.calc)
	);

	// ************************************************************
	// port value next state
	// ************************************************************
	// enabled input pins refuse software writes
	assign ro_mask = enable_reg & ~dir_reg;

	// software write first, hardware transfer wins on collision
	always_comb begin
		sw_mask = 16'h0000;
		if (wr_fire && reg_hit(addr_lo, `TPO_OFF_VALUE_A)) begin
			sw_mask[7:0] = ~ro_mask[7:0];
		end
		if (wr_fire && reg_hit(addr_lo, `TPO_OFF_VALUE_B)) begin
			sw_mask[15:8] = ~ro_mask[15:8];
		end
		value_next = (value_reg & ~sw_mask) | ({pwdata_i[7:0], pwdata_i[7:0]} & sw_mask);
		value_next = (value_next & ~upd_if.load) | (staged_reg & upd_if.load);
	end

	// port value register
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			value_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
		end else if (ce_i) begin
			if (hw_standby_i) begin
				value_reg <= {`TPO_RST_ZERO, `TPO_RST_ZERO};
			end else begin
				value_reg <= value_next;
			end
		end
	end

	// ************************************************************
	// pin drive
	// ************************************************************
	// pins follow the value register one edge later
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pin_out_reg <= 16'h0000;
			pin_oe_reg  <= 16'h0000;
			active_reg  <= 16'h0000;
		end else if (ce_i) begin
			pin_out_reg <= value_reg;
			pin_oe_reg  <= dir_reg;
			active_reg  <= dir_reg & enable_reg;
		end
	end

	// ************************************************************
	// read data and answer
	// ************************************************************
	// read mux, unmapped offsets answer with an error
	always_comb begin
		prdata_next  = 32'h0000_0000;
		pslverr_next = 1'b0;
		case (addr_lo)
			`TPO_OFF_STAGED_A:   prdata_next[7:0] = staged_reg[7:0];
			`TPO_OFF_STAGED_B:   prdata_next[7:0] = staged_reg[15:8];
			`TPO_OFF_VALUE_A:    prdata_next[7:0] = value_reg[7:0];
			`TPO_OFF_VALUE_B:    prdata_next[7:0] = value_reg[15:8];
			`TPO_OFF_DIR_A:      prdata_next[7:0] = dir_reg[7:0];
			`TPO_OFF_DIR_B:      prdata_next[7:0] = dir_reg[15:8];
			`TPO_OFF_ENABLE_A:   prdata_next[7:0] = enable_reg[7:0];
			`TPO_OFF_ENABLE_B:   prdata_next[7:0] = enable_reg[15:8];
			`TPO_OFF_TRIG_SEL:   prdata_next[7:0] = trig_sel_reg;
			`TPO_OFF_GROUP_MODE: prdata_next[7:0] = group_mode_reg;
			`TPO_OFF_PIN_LEVEL:  prdata_next[15:0] = pin_sync_reg;
			default:             pslverr_next = 1'b1;
		endcase
		if (paddr_i[ADDR_W-1:0] != ADDR_W'(addr_lo)) begin
			prdata_next  = 32'h0000_0000;
			pslverr_next = 1'b1;
		end
	end

	// no wait state: answer in the first access cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_reg <= setup_phase;
			if (setup_phase) begin
				pslverr_reg <= pslverr_next;
				prdata_reg  <= pwrite_i ? 32'h0000_0000 : prdata_next;
			end else begin
				pslverr_reg <= 1'b0;
				prdata_reg  <= 32'h0000_0000;
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata_o         = prdata_reg;
	assign pready_o         = pready_reg;
	assign pslverr_o        = pslverr_reg;
	assign pin_o            = pin_out_reg;
	assign pin_oe_o         = pin_oe_reg;
	assign pattern_active_o = active_reg;

endmodule : timed_pattern_output

// File: tb/timer_match_model.sv
`timescale 1ns/10ps
// ************
// timer channel model: compare match events
// ************
module timer_match_model (
	input  wire logic       clk_sys_i,
	output logic      [3:0] cm_a_o,
	output logic      [3:0] cm_b_o
);
	// quiet until a period is fired
	initial begin
		cm_a_o = 4'h0;
		cm_b_o = 4'h0;
	end

	// one-cycle pulse of match b (b high) or match a on one channel
	task automatic fire(input int ch, input logic b);
		@(posedge clk_sys_i);
		if (b) cm_b_o[ch] <= 1'b1;
		else cm_a_o[ch] <= 1'b1;
		@(posedge clk_sys_i);
		cm_a_o <= 4'h0;
		cm_b_o <= 4'h0;
	endtask : fire
endmodule : timer_match_model

// File: tb/timed_pattern_output_chk.sv
`timescale 1ns/10ps
`include "timed_pattern_output_defines.svh"
// ************
// port checker
// ************
module timed_pattern_output_chk #(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_sys_i,
	input wire logic              rst_i,
	input wire logic              ce_i,
	input wire logic              hw_standby_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0]       prdata_o,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	input wire logic [3:0]        cm_a_i,
	input wire logic [3:0]        cm_b_i,
	input wire logic [15:0]       pin_o,
	input wire logic [15:0]       pin_oe_o,
	input wire logic [15:0]       pattern_active_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic cause;

	// any event that may move the value register
	assign cause = (|cm_a_i) | (|cm_b_i) | hw_standby_i | (psel_i & penable_i & pwrite_i);

	sequence setup_s;
		ce_i && !hw_standby_i && psel_i && !penable_i && !pready_o;
	endsequence
	sequence rd_at_s(logic [7:0] off);
		pready_o && !pwrite_i && !pslverr_o && paddr_i == ADDR_W'(off);
	endsequence

	answer_next_a: assert property (setup_s |=> pready_o)
		else $error("setup not answered next cycle");
	mode_high_a: assert property (rd_at_s(`TPO_OFF_GROUP_MODE) |-> prdata_o[7:4] == 4'hF)
		else $error("mode upper bits not high");
	active_dir_a: assert property ((pattern_active_o & ~pin_oe_o) == 16'h0000)
		else $error("pattern pin without direction");
	dir_read_a: assert property (rd_at_s(`TPO_OFF_DIR_A) |-> prdata_o[7:0] == pin_oe_o[7:0])
		else $error("direction read differs from enables");
	value_read_a: assert property (rd_at_s(`TPO_OFF_VALUE_B) |-> prdata_o[7:0] == pin_o[15:8])
		else $error("value read differs from pins");
	pin_cause_a: assert property ($changed(pin_o) |-> $past(cause, 2))
		else $error("pins moved without event");
	reset_low_a: assert property ($fell(rst_i) |-> pin_o == 16'h0 && pattern_active_o == 16'h0)
		else $error("pins not low after reset");
	standby_clear_a: assert property (hw_standby_i && ce_i |-> ##2 pin_o == 16'h0 && pin_oe_o == 16'h0)
		else $error("standby did not clear pins");
endmodule : timed_pattern_output_chk

bind timed_pattern_output timed_pattern_output_chk #(.ADDR_W(ADDR_W)) i_chk (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .hw_standby_i(hw_standby_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cm_a_i(cm_a_i),
	.cm_b_i(cm_b_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pattern_active_o(pattern_active_o)
);

// File: tb/timed_pattern_output_tb.sv
`timescale 1ns/10ps
`include "timed_pattern_output_defines.svh"
module timed_pattern_output_tb
	import timed_pattern_output_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        hw_standby_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic [3:0]  cm_a_i;
	logic [3:0]  cm_b_i;
	logic [15:0] pin_i = 16'h0;
	logic [15:0] pin_o;
	logic [15:0] pin_oe_o;
	logic [15:0] pattern_active_o;
	logic [15:0] val = 16'h0;
	logic [7:0]  rv[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 8'hFF, 8'hF0};
	logic [32:0] notes[$];
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	// ************
	// clock, design and timer model
	// ************
	always #5 clk_sys_i = ~clk_sys_i;

	timed_pattern_output i_timed_pattern_output (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .hw_standby_i(hw_standby_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .cm_a_i(cm_a_i), .cm_b_i(cm_b_i), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_o(pin_oe_o), .pattern_active_o(pattern_active_o)
	);
	timer_match_model i_timer_match_model (.clk_sys_i(clk_sys_i), .cm_a_o(cm_a_i), .cm_b_o(cm_b_i));

	// ************
	// tasks
	// ************
	task automatic report_and_stop;
		if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// one bus transfer; a read leaves its expected answer in the queue
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [32:0] exp);
		@(posedge clk_sys_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= {24'h0, d};
		if (!w) notes.push_back(exp);
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		apb(1'b0, a, 8'h00, {25'h0, d});
	endtask : rd

	// pins two edges after a match
	task automatic pins(input logic [15:0] exp);
		repeat (2) @(negedge clk_sys_i);
		samples_checked++;
		if (pin_o !== exp) begin
			fails++;
			$display("mismatch at %0t: pins %h expected %h", $time, pin_o, exp);
		end
	endtask : pins

	// ************
	// read answer watcher and run limit
	// ************
	// read data is taken at the rising edge that sees pready high
	always @(posedge clk_sys_i) begin
		if (psel_i && penable_i && pready_o === 1'b1 && pwrite_i === 1'b0) begin
			samples_checked++;
			if (notes.size() == 0 || {pslverr_o, prdata_o} !== notes[0]) begin
				fails++;
				$display("mismatch at %0t: read answer %h", $time, {pslverr_o, prdata_o});
			end
			if (notes.size() > 0) void'(notes.pop_front());
		end
	end

	// cycle ceiling
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			report_and_stop();
		end
	end

	// ************
	// scenarios
	// ************
	initial begin
		int          ch;
		int          k;
		logic [3:0]  md;
		logic [15:0] s;
		logic [15:0] m;
		void'($urandom(89569));
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		foreach (rv[i]) rd(8'(4 * i), rv[i]);
		apb(1'b0, 8'h2C, 8'h00, 33'h1_0000_0000);
		wr(`TPO_OFF_GROUP_MODE, 8'h05);
		rd(`TPO_OFF_GROUP_MODE, 8'hF5);
		wr(`TPO_OFF_GROUP_MODE, 8'h00);
		wr(`TPO_OFF_DIR_A, 8'hFF);
		wr(`TPO_OFF_DIR_B, 8'hFF);
		wr(`TPO_OFF_ENABLE_A, 8'hFF);
		wr(`TPO_OFF_ENABLE_B, 8'hFF);
		// normal groups: only match a of the picked channel loads
		for (ch = 0; ch < 4; ch++) begin
			s = 16'($urandom);
			wr(`TPO_OFF_TRIG_SEL, {4{ch[1:0]}});
			wr(`TPO_OFF_STAGED_A, s[7:0]);
			wr(`TPO_OFF_STAGED_B, s[15:8]);
			i_timer_match_model.fire(ch, 1'b1);
			i_timer_match_model.fire((ch + 1) % 4, 1'b0);
			pins(val);
			i_timer_match_model.fire(ch, 1'b0);
			val = s;
			pins(val);
			rd(`TPO_OFF_VALUE_B, val[15:8]);
		end
		// port a: high half plain output, low half enabled input
		wr(`TPO_OFF_DIR_A, 8'hF0);
		wr(`TPO_OFF_ENABLE_A, 8'h0F);
		rd(`TPO_OFF_DIR_A, 8'hF0);
		wr(`TPO_OFF_VALUE_A, ~val[7:0]);
		val[7:4] = ~val[7:4];
		rd(`TPO_OFF_VALUE_A, val[7:0]);
		wr(`TPO_OFF_STAGED_A, ~val[7:0]);
		i_timer_match_model.fire(3, 1'b0);
		val[3:0] = ~val[3:0];
		rd(`TPO_OFF_VALUE_A, val[7:0]);
		wr(`TPO_OFF_DIR_A, 8'hFF);
		wr(`TPO_OFF_ENABLE_A, 8'hFF);
		// mixed modes, then all non-overlap: match b moves only the zeros of non-overlap groups
		for (k = 1; k < 4; k++) begin
			md = 4'(5 * k);
			m = {{4{md[3]}}, {4{md[2]}}, {4{md[1]}}, {4{md[0]}}};
			s = 16'($urandom);
			wr(`TPO_OFF_GROUP_MODE, {4'h0, md});
			wr(`TPO_OFF_STAGED_A, s[7:0]);
			wr(`TPO_OFF_STAGED_B, s[15:8]);
			i_timer_match_model.fire(3, 1'b1);
			val = (val & s & m) | (val & ~m);
			pins(val);
			i_timer_match_model.fire(3, 1'b0);
			val = s;
			pins(val);
		end
		// clock enable low: a match in that cycle is lost
		s = 16'($urandom);
		wr(`TPO_OFF_STAGED_A, s[7:0]);
		wr(`TPO_OFF_STAGED_B, s[15:8]);
		ce_i <= 1'b0;
		i_timer_match_model.fire(3, 1'b0);
		ce_i <= 1'b1;
		pins(val);
		i_timer_match_model.fire(3, 1'b0);
		val = s;
		pins(val);
		// pin levels reach the level register through two stages
		s = 16'($urandom);
		pin_i <= s;
		repeat (2) @(posedge clk_sys_i);
		apb(1'b0, `TPO_OFF_PIN_LEVEL, 8'h00, {17'h0, s});
		// hardware standby reloads every writable register
		@(posedge clk_sys_i);
		hw_standby_i <= 1'b1;
		@(posedge clk_sys_i);
		hw_standby_i <= 1'b0;
		rd(`TPO_OFF_GROUP_MODE, 8'hF0);
		rd(`TPO_OFF_TRIG_SEL, 8'hFF);
		pins(16'h0000);
		repeat (3) @(posedge clk_sys_i);
		report_and_stop();
	end
endmodule : timed_pattern_output_tb
